// File: src/csc_pkg.sv
// Constants and types for the converter sequencing control bank.
// Assumes one 100 MHz clock and an AHB-Lite slave with 32-bit data.
// Overview of operation
// - Undervoltage action code ignores, shuts down, or resets
// - Every undervoltage event always raises an interrupt
// - Source field picks hardware input one, two, either
// - Hardware control takes ON or SLEEP voltage code
// - Hardware control mode field sets buck mode
// - Overvoltage protect bit enables buck protection
// - ON slot: never, timeslot 1-5, hardware enables
// - ON mode field sets buck mode when on
// - Voltage codes above 66h clamp to maximum
// - ON code split; upper five bits preloaded, lower two cleared
// - SLEEP slot: transition slots or disable slots
// - Hardware-assigned buck enters sleep at disable slot
// - SLEEP mode and voltage fields used in sleep
// - Outside sleep, boost disabled while chosen hardware input asserted
// - Boost range field, write needs security key
// - Boost feedback from sink one or two
// - Boost sleep enable gates boost in sleep
// - External enable forced low by hardware inputs
// - External enable sleep slot deasserts in slots 5-1
package csc_pkg;
  // Stored registers and their word indices (byte address = index * 4)
  localparam int NREG = 8;
  localparam int R_BCTL = 0;
  localparam int R_BON = 1;
  localparam int R_BSLP = 2;
  localparam int R_BST = 3;
  localparam int R_BSTS = 4;
  localparam int R_EXT1 = 5;
  localparam int R_SWEN = 7;
  localparam logic [NREG-1:0][15:0] REG_IDX = {
    16'h40F0, 16'h4067, 16'h4066, 16'h4065,
    16'h4064, 16'h4063, 16'h4062, 16'h4061};
  localparam logic [15:0] IDX_STAT = 16'h40F1;
  // Writable bits per register; all others read zero
  localparam logic [NREG-1:0][15:0] WMASK = {
    16'h0007, 16'hF9E0, 16'hF9E0, 16'h0100,
    16'hD90D, 16'hE37F, 16'hE37F, 16'hDF80};
  // Reset values per register
  localparam logic [NREG-1:0][15:0] RSTV = {
    16'h0000, 16'h0000, 16'h0000, 16'h0000,
    16'h0104, 16'h0300, 16'h0100, 16'h0300};
  // Field positions
  localparam int F_UVACT = 14;
  localparam int F_SLOT = 13;
  localparam int F_SRC = 11;
  localparam int F_VSEL = 10;
  localparam int F_MODE = 8;
  localparam int F_HWCB = 8;
  localparam int F_OVP = 7;
  localparam int F_XSLP = 5;
  localparam int F_VHI = 2;
  localparam int F_RNG = 2;
  localparam int F_FB = 0;
  localparam int F_SW_BST = 0;
  localparam int F_SW_EXT = 1;
  // Status register bits
  localparam int ST_BUCK = 0;
  localparam int ST_SLP = 1;
  localparam int ST_BST = 2;
  localparam int ST_EXT = 3;
  localparam int ST_BSLP = 5;
  // Encodings
  typedef enum logic [1:0] {CSC_UV_IGNORE, CSC_UV_SHUT, CSC_UV_RESET,
                            CSC_UV_RSVD} csc_uv_t;
  localparam logic [1:0] HWC_M_OFF = 2'h1;
  localparam logic [2:0] SLOT_NONE = 3'h0;
  localparam logic [2:0] SLOT_LAST = 3'h5;
  localparam logic [2:0] SLP_T5 = 3'h0;
  localparam logic [2:0] SLP_T3 = 3'h6;
  localparam logic [2:0] SLP_T1 = 3'h7;
  localparam logic [2:0] TS1 = 3'h1;
  localparam logic [2:0] TS3 = 3'h3;
  localparam logic [2:0] TS5 = 3'h5;
  localparam logic [2:0] SLP_BASE = 3'h6;
  localparam logic [6:0] VC_MAX = 7'h66;
  localparam int HT_ACT = 1;
  localparam logic [3:0] SEL_STAT = 4'hE;
  localparam logic [3:0] SEL_NONE = 4'hF;
endpackage

// File: src/csc_sync.sv
// Three-stage synchroniser for pins entering the hclk domain.
// Assumes inputs are asynchronous levels; output changes once stages agree.
`timescale 1ns/1ps
module csc_sync #(
  parameter int W = 6
) (
  input  wire logic         hclk,
  input  wire logic         hresetn,
  input  wire logic         clk_en,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  // -------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------
  typedef struct packed {
    logic [W-1:0] s1;  // First stage, read only by s2
    logic [W-1:0] s2;  // Second stage
    logic [W-1:0] s3;  // Third stage
    logic [W-1:0] q;   // Accepted level
  } csc_sync_t;

  csc_sync_t s_q;  // Registered state
  csc_sync_t s_d;  // Next state
  logic [W-1:0] agree;  // Stages two and three equal

  // Shift and accept agreeing bits
  always_comb begin
    s_d = s_q;
    s_d.s1 = d_in;
    s_d.s2 = s_q.s1;
    s_d.s3 = s_q.s2;
    agree = ~(s_q.s2 ^ s_q.s3);
    s_d.q = (s_q.s3 & agree) | (s_q.q & ~agree);
  end

  // Register, frozen while clock enable is low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= '0;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign q_out = s_q.q;
endmodule

// File: src/csc_top.sv
// Register bank and control for the buck, the boost and two external
// enables. Assumes AHB-Lite single word transfers, a sequencer on hclk
// giving timeslot strobes, and asynchronous pins for hardware inputs.
`timescale 1ns/1ps
module csc_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        clk_en,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic      [31:0] hrdata,
  output logic             hresp,
  input  wire logic [1:0]  hwctl_pin,
  input  wire logic [1:0]  hwen_pin,
  input  wire logic [1:0]  uv_pin,
  input  wire logic        seq_strobe,
  input  wire logic        seq_sleep,
  input  wire logic [2:0]  seq_slot,
  input  wire logic        key_open,
  input  wire logic        otp_load,
  input  wire logic [4:0]  otp_vcode,
  output logic             buck_en,
  output logic      [1:0]  buck_mode,
  output logic      [6:0]  buck_vcode,
  output logic             buck_ovp,
  output logic             boost_en,
  output logic      [1:0]  boost_range,
  output logic             boost_fb,
  output logic      [1:0]  ext_en,
  output logic      [1:0]  uv_irq,
  output logic             dev_reset_req
);
  // -------------------------------------------------------------------
  // State
  // -------------------------------------------------------------------
  typedef struct packed {
    logic [csc_pkg::NREG-1:0][15:0] regs;  // Register contents
    logic        ph_valid;     // Data phase pending
    logic        ph_write;     // Pending phase is a write
    logic [3:0]  ph_sel;       // Decoded register of pending phase
    logic [31:0] hrdata;       // Read data
    logic        hreadyout;    // Always ready
    logic        hresp;        // Always OKAY
    logic        sleep;        // Device in sleep sequence
    logic        buck_on;      // Buck enabled by sequence
    logic        buck_slp;     // Buck using sleep settings
    logic [1:0]  ext_on;       // External enables set by sequence
    logic [1:0]  uv_prev;      // Last undervoltage levels
    logic        buck_en;      // Buck enable output
    logic [1:0]  buck_mode;    // Buck mode output
    logic [6:0]  buck_vcode;   // Buck voltage code output
    logic        buck_ovp;     // Overvoltage protect output
    logic        boost_en;     // Boost enable output
    logic [1:0]  boost_range;  // Boost range output
    logic        boost_fb;     // Boost feedback select output
    logic [1:0]  ext_en;       // External enable outputs
    logic [1:0]  uv_irq;       // Undervoltage interrupt pulses
    logic        dev_reset;    // Device reset request pulse
  } csc_state_t;

  localparam csc_state_t S_RST = '{
    regs: csc_pkg::RSTV, hreadyout: 1'b1,
    ph_sel: csc_pkg::SEL_NONE, default: '0};

  csc_state_t  s_q;        // Registered state
  csc_state_t  s_d;        // Next state
  logic [5:0]  pins_s;     // Synchronised pins
  logic [1:0]  hw;         // Hardware control inputs
  logic [1:0]  hen;        // Hardware enable inputs
  logic [1:0]  uv;         // Undervoltage levels
  logic [1:0]  uv_rise;    // New undervoltage events
  logic        up_ev;      // Startup timeslot strobe
  logic        dn_ev;      // Sleep timeslot strobe
  logic [2:0]  on_code;    // Buck ON slot code
  logic [2:0]  slp_code;   // Buck SLEEP slot code
  logic        hwa;        // Buck tied to a hardware enable
  logic        b_hwc;      // Buck under hardware control
  logic        bst_hwc;    // Boost hardware source asserted
  logic        a_take;     // Address phase taken
  logic [3:0]  asel;       // Decoded register of address phase
  logic [15:0] wm;         // Effective write mask
  logic [15:0] rdv;        // Read value
  logic [6:0]  vsel;       // Buck voltage before clamp
  logic [2:0]  xc;         // External ON slot code
  logic [2:0]  xs;         // External SLEEP slot code
  logic [15:0] xr;         // External register
  logic        sw_bst;     // Boost software enable

  // -------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------
  // Source 01 input one, 10 input two, 11 either
  function automatic logic hwc_pick(input logic [1:0] src,
                                    input logic [1:0] h);
    return (src[0] & h[0]) | (src[1] & h[1]);
  endfunction

  // Code names timeslot one to five
  function automatic logic ts_ok(input logic [2:0] c);
    return (c != csc_pkg::SLOT_NONE) && (c <= csc_pkg::SLOT_LAST);
  endfunction

  // Pins cross into hclk through three stages
  csc_sync #(
    .W(6)
  ) u_sync (
    .hclk    (hclk),
    .hresetn (hresetn),
    .clk_en  (clk_en),
    .d_in    ({uv_pin, hwen_pin, hwctl_pin}),
    .q_out   (pins_s)
  );

  assign hw = pins_s[1:0];
  assign hen = pins_s[3:2];
  assign uv = pins_s[5:4];
  assign uv_rise = uv & ~s_q.uv_prev;
  assign up_ev = seq_strobe & ~seq_sleep;
  assign dn_ev = seq_strobe & seq_sleep;
  assign on_code = s_q.regs[csc_pkg::R_BON][csc_pkg::F_SLOT+:3];
  assign slp_code = s_q.regs[csc_pkg::R_BSLP][csc_pkg::F_SLOT+:3];
  assign hwa = on_code[2] & on_code[1];
  assign b_hwc = hwc_pick(s_q.regs[csc_pkg::R_BCTL][csc_pkg::F_SRC+:2], hw);
  assign bst_hwc = hwc_pick(s_q.regs[csc_pkg::R_BST][csc_pkg::F_SRC+:2], hw);
  assign sw_bst = s_q.regs[csc_pkg::R_SWEN][csc_pkg::F_SW_BST];
  assign a_take = hsel & hready & htrans[csc_pkg::HT_ACT];

  // -------------------------------------------------------------------
  // Next state
  // -------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.uv_irq = '0;
    s_d.dev_reset = 1'b0;
    wm = '0;
    xc = '0;
    xs = '0;
    xr = '0;
    // Data phase write, masked to defined bits
    if (s_q.ph_valid && s_q.ph_write && !s_q.ph_sel[3]) begin
      wm = csc_pkg::WMASK[s_q.ph_sel[2:0]];
      if (s_q.ph_sel[2:0] == 3'(csc_pkg::R_BST) && !key_open) begin
        wm[csc_pkg::F_RNG+:2] = 2'h0;
      end
      s_d.regs[s_q.ph_sel[2:0]] = (hwdata[15:0] & wm)
                                | (s_q.regs[s_q.ph_sel[2:0]] & ~wm);
    end
    // Preload of upper ON code bits, lower bits cleared
    if (otp_load) begin
      s_d.regs[csc_pkg::R_BON][csc_pkg::F_VHI+:5] = otp_vcode;
      s_d.regs[csc_pkg::R_BON][csc_pkg::F_VHI-1:0] = '0;
    end
    // Sequencer phase
    if (up_ev) begin
      s_d.sleep = 1'b0;
      s_d.buck_slp = 1'b0;
    end
    if (dn_ev) begin
      s_d.sleep = 1'b1;
    end
    // Buck ON slot
    if (hwa) begin
      s_d.buck_on = hen[on_code[0]];
    end else if (up_ev && ts_ok(on_code) && seq_slot == on_code) begin
      s_d.buck_on = 1'b1;
    end
    // Buck SLEEP slot
    if (dn_ev) begin
      if ((slp_code == csc_pkg::SLP_T5 && seq_slot == csc_pkg::TS5)
          || (slp_code == csc_pkg::SLP_T3 && seq_slot == csc_pkg::TS3)
          || (slp_code == csc_pkg::SLP_T1 && seq_slot == csc_pkg::TS1)) begin
        s_d.buck_slp = 1'b1;
      end else if (ts_ok(slp_code)
                   && seq_slot == csc_pkg::SLP_BASE - slp_code) begin
        if (hwa) begin
          s_d.buck_slp = 1'b1;
        end else begin
          s_d.buck_on = 1'b0;
        end
      end
    end
    // Undervoltage handling, shutdown wins over other enables
    s_d.uv_prev = uv;
    s_d.uv_irq = uv_rise;
    if (uv_rise[0]) begin
      unique case (s_q.regs[csc_pkg::R_BCTL][csc_pkg::F_UVACT+:2])
        csc_pkg::CSC_UV_SHUT: s_d.buck_on = 1'b0;
        csc_pkg::CSC_UV_RESET: s_d.dev_reset = 1'b1;
        default: ;  // Ignore and reserved
      endcase
    end
    if (uv_rise[1]) begin
      unique case (s_q.regs[csc_pkg::R_BST][csc_pkg::F_UVACT+:2])
        csc_pkg::CSC_UV_SHUT: s_d.regs[csc_pkg::R_SWEN][csc_pkg::F_SW_BST] = 1'b0;
        csc_pkg::CSC_UV_RESET: s_d.dev_reset = 1'b1;
        default: ;  // Ignore and reserved
      endcase
    end
    // Buck operating point
    if (b_hwc) begin
      s_d.buck_mode = s_q.regs[csc_pkg::R_BCTL][csc_pkg::F_MODE+:2];
      vsel = s_q.regs[csc_pkg::R_BCTL][csc_pkg::F_VSEL]
           ? s_q.regs[csc_pkg::R_BSLP][6:0]
           : s_q.regs[csc_pkg::R_BON][6:0];
      s_d.buck_en = s_d.buck_on && (s_d.buck_mode != csc_pkg::HWC_M_OFF);
    end else if (s_d.buck_slp) begin
      s_d.buck_mode = s_q.regs[csc_pkg::R_BSLP][csc_pkg::F_MODE+:2];
      vsel = s_q.regs[csc_pkg::R_BSLP][6:0];
      s_d.buck_en = s_d.buck_on;
    end else begin
      s_d.buck_mode = s_q.regs[csc_pkg::R_BON][csc_pkg::F_MODE+:2];
      vsel = s_q.regs[csc_pkg::R_BON][6:0];
      s_d.buck_en = s_d.buck_on;
    end
    s_d.buck_vcode = (vsel > csc_pkg::VC_MAX) ? csc_pkg::VC_MAX : vsel;
    s_d.buck_ovp = s_q.regs[csc_pkg::R_BCTL][csc_pkg::F_OVP];
    // Boost control
    if (s_q.sleep) begin
      s_d.boost_en = s_q.regs[csc_pkg::R_BSTS][csc_pkg::F_HWCB] & sw_bst;
    end else begin
      s_d.boost_en = sw_bst & ~(s_q.regs[csc_pkg::R_BST][csc_pkg::F_HWCB]
                                & bst_hwc);
    end
    s_d.boost_range = s_q.regs[csc_pkg::R_BST][csc_pkg::F_RNG+:2];
    s_d.boost_fb = s_q.regs[csc_pkg::R_BST][csc_pkg::F_FB];
    // External enables, one pass per output
    for (int i = 0; i < 2; i++) begin
      xr = s_q.regs[csc_pkg::R_EXT1+i];
      xc = xr[csc_pkg::F_SLOT+:3];
      xs = xr[csc_pkg::F_XSLP+:3];
      if (xc[2] & xc[1]) begin
        s_d.ext_on[i] = hen[xc[0]];
      end else if (up_ev && ts_ok(xc) && seq_slot == xc) begin
        s_d.ext_on[i] = 1'b1;
      end
      if (dn_ev && ts_ok(xs) && seq_slot == csc_pkg::SLP_BASE - xs) begin
        s_d.ext_on[i] = 1'b0;
      end
      s_d.ext_en[i] = (s_d.ext_on[i]
                      | (s_q.regs[csc_pkg::R_SWEN][csc_pkg::F_SW_EXT+i] & ~s_d.sleep))
                    & ~(xr[csc_pkg::F_HWCB]
                        & hwc_pick(xr[csc_pkg::F_SRC+:2], hw));
    end
    // Address decode
    asel = csc_pkg::SEL_NONE;
    for (int i = 0; i < csc_pkg::NREG; i++) begin
      if (haddr[31:2] == {14'h0, csc_pkg::REG_IDX[i]}) begin
        asel = 4'(i);
      end
    end
    if (haddr[31:2] == {14'h0, csc_pkg::IDX_STAT}) begin
      asel = csc_pkg::SEL_STAT;
    end
    // Read value, forwarded from this cycle's write
    rdv = '0;
    if (!asel[3]) begin
      rdv = s_d.regs[asel[2:0]];
    end else if (asel == csc_pkg::SEL_STAT) begin
      rdv[csc_pkg::ST_BUCK] = s_q.buck_en;
      rdv[csc_pkg::ST_SLP] = s_q.sleep;
      rdv[csc_pkg::ST_BST] = s_q.boost_en;
      rdv[csc_pkg::ST_EXT+:2] = s_q.ext_en;
      rdv[csc_pkg::ST_BSLP] = s_q.buck_slp;
    end
    // Address phase capture
    s_d.ph_valid = a_take;
    if (a_take) begin
      s_d.ph_write = hwrite;
      s_d.ph_sel = asel;
      if (!hwrite) begin
        s_d.hrdata = {16'h0, rdv};
      end
    end
  end

  // -------------------------------------------------------------------
  // Registers
  // -------------------------------------------------------------------
  // State frozen while clock enable is low
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_q <= S_RST;
    end else if (clk_en) begin
      s_q <= s_d;
    end
  end

  assign hreadyout = s_q.hreadyout;
  assign hrdata = s_q.hrdata;
  assign hresp = s_q.hresp;
  assign buck_en = s_q.buck_en;
  assign buck_mode = s_q.buck_mode;
  assign buck_vcode = s_q.buck_vcode;
  assign buck_ovp = s_q.buck_ovp;
  assign boost_en = s_q.boost_en;
  assign boost_range = s_q.boost_range;
  assign boost_fb = s_q.boost_fb;
  assign ext_en = s_q.ext_en;
  assign uv_irq = s_q.uv_irq;
  assign dev_reset_req = s_q.dev_reset;

  // -------------------------------------------------------------------
  // Assertions
  // -------------------------------------------------------------------
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);

  // Startup strobe in the buck's own slot
  sequence s_up_hit;
    clk_en && up_ev && ts_ok(on_code) && seq_slot == on_code && !uv_rise[0];
  endsequence

  // Sleep strobe in the buck's disable slot
  sequence s_dn_hit;
    clk_en && dn_ev && ts_ok(slp_code) && seq_slot == csc_pkg::SLP_BASE - slp_code;
  endsequence

  // Read of an unmapped address
  sequence s_rd_none;
    clk_en && a_take && !hwrite && asel == csc_pkg::SEL_NONE;
  endsequence

  a_uv_reset: assert property (clk_en && uv_rise[0] && s_q.regs[csc_pkg::R_BCTL][15:14]
    == csc_pkg::CSC_UV_RESET |=> dev_reset_req) else $error("no reset request");
  a_uv_shut: assert property (clk_en && uv_rise[0] && s_q.regs[csc_pkg::R_BCTL][15:14]
    == csc_pkg::CSC_UV_SHUT |=> !s_q.buck_on) else $error("buck not shut");
  a_uv_irq: assert property (clk_en && uv_rise[1]
    |=> uv_irq[1] ##1 (!$past(clk_en) || !uv_irq[1]))
    else $error("irq not one pulse");
  a_hwc_src: assert property (clk_en && !b_hwc && !s_d.buck_slp |=> buck_mode
    == $past(s_q.regs[csc_pkg::R_BON][9:8])) else $error("source ignored");
  a_hwc_vsel: assert property (clk_en && b_hwc && s_q.regs[csc_pkg::R_BCTL][10]
    && s_q.regs[csc_pkg::R_BSLP][6:0] <= csc_pkg::VC_MAX |=> buck_vcode
    == $past(s_q.regs[csc_pkg::R_BSLP][6:0])) else $error("wrong vcode");
  a_hwc_mode: assert property (clk_en && b_hwc && s_q.regs[csc_pkg::R_BCTL][9:8]
    == csc_pkg::HWC_M_OFF |=> !buck_en) else $error("buck not off");
  a_ovp_bit: assert property (clk_en |=> buck_ovp
    == $past(s_q.regs[csc_pkg::R_BCTL][7])) else $error("ovp mismatch");
  a_on_slot: assert property (s_up_hit |=> s_q.buck_on) else $error("no enable");
  a_on_never: assert property (clk_en && on_code == csc_pkg::SLOT_NONE && !s_q.buck_on
    |=> !s_q.buck_on) else $error("enabled by code 0");
  a_on_mode: assert property (clk_en && !b_hwc && !s_d.buck_slp && !hwa |=> buck_mode
    == $past(s_q.regs[csc_pkg::R_BON][9:8])) else $error("on mode wrong");
  a_vc_clamp: assert property (buck_vcode <= csc_pkg::VC_MAX)
    else $error("vcode over max");
  a_otp_split: assert property (clk_en && otp_load |=> s_q.regs[csc_pkg::R_BON][1:0]
    == 2'h0 && s_q.regs[csc_pkg::R_BON][6:2] == $past(otp_vcode))
    else $error("preload wrong");
  a_slp_dis: assert property ((s_dn_hit and !hwa) |=> !s_q.buck_on)
    else $error("not disabled");
  a_slp_hwa: assert property ((s_dn_hit and hwa) |=> s_q.buck_slp)
    else $error("no sleep entry");
  a_slp_mode: assert property (clk_en && !b_hwc && s_q.buck_slp && !up_ev |=> buck_mode
    == $past(s_q.regs[csc_pkg::R_BSLP][9:8])) else $error("sleep mode wrong");
  a_bst_hwc: assert property (clk_en && !s_q.sleep && s_q.regs[csc_pkg::R_BST][8]
    && bst_hwc |=> !boost_en) else $error("boost not off");
  a_bst_range: assert property (clk_en && s_q.ph_valid && s_q.ph_write && !key_open
    && s_q.ph_sel == 4'(csc_pkg::R_BST) |=> $stable(s_q.regs[csc_pkg::R_BST][3:2]))
    else $error("range written");
  a_bst_fb: assert property (clk_en |=> boost_fb
    == $past(s_q.regs[csc_pkg::R_BST][0])) else $error("fb mismatch");
  a_bst_sleep: assert property (clk_en && s_q.sleep && !s_q.regs[csc_pkg::R_BSTS][8]
    |=> !boost_en) else $error("boost on in sleep");
  a_ext_force: assert property (clk_en && s_q.regs[csc_pkg::R_EXT1][8]
    && hwc_pick(s_q.regs[csc_pkg::R_EXT1][12:11], hw) |=> !ext_en[0])
    else $error("ext not forced");
  a_ext_sleep: assert property (clk_en && dn_ev && s_q.regs[csc_pkg::R_EXT1][7:5]
    == 3'h1 && seq_slot == csc_pkg::TS5 && !s_q.regs[csc_pkg::R_EXT1][14]
    |=> !ext_en[0]) else $error("ext not dropped");
  a_rd_zero: assert property (s_rd_none |=> hrdata == 32'h0)
    else $error("unmapped read nonzero");
endmodule

// File: verif/csc_top_test.sv
// Self-checking bench for the converter sequencing control bank.
// Assumes csc_top answers AHB-Lite with zero waits and has registered outputs.
`timescale 1ns/1ps
module csc_top_test;
  // ------------------------------
  // Signals and device under test
  // ------------------------------
  logic        hclk, hresetn, clk_en, hsel, hwrite, hready, hreadyout, hresp;
  logic        seq_strobe, seq_sleep, key_open, otp_load, buck_en, buck_ovp;
  logic        boost_en, boost_fb, dev_reset_req;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0]  htrans, hwctl_pin, hwen_pin, uv_pin, buck_mode, boost_range, ext_en, uv_irq;
  logic [2:0]  hsize, seq_slot;
  logic [4:0]  otp_vcode;
  logic [6:0]  buck_vcode;
  int          mismatches = 0;
  int          cmp_count = 0;
  assign hready = hreadyout; // Single slave drives bus ready
  csc_top dut (.hclk(hclk), .hresetn(hresetn), .clk_en(clk_en), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
    .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .hwctl_pin(hwctl_pin),
    .hwen_pin(hwen_pin), .uv_pin(uv_pin), .seq_strobe(seq_strobe), .seq_sleep(seq_sleep),
    .seq_slot(seq_slot), .key_open(key_open), .otp_load(otp_load), .otp_vcode(otp_vcode),
    .buck_en(buck_en), .buck_mode(buck_mode), .buck_vcode(buck_vcode), .buck_ovp(buck_ovp),
    .boost_en(boost_en), .boost_range(boost_range), .boost_fb(boost_fb), .ext_en(ext_en),
    .uv_irq(uv_irq), .dev_reset_req(dev_reset_req));
  // Free running 100 MHz clock
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // ------------------------------
  // Helper tasks
  // ------------------------------
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  // One single AHB transfer; read data lands in rd
  task automatic bus(input logic w, input logic [15:0] ix, input logic [31:0] wd);
    hsel   <= 1'b1;
    haddr  <= {14'h0, ix, 2'b00};
    htrans <= 2'h2;
    hwrite <= w;
    do @(posedge hclk); while (hready !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge hclk); while (hready !== 1'b1);
    rd = hrdata;
    chk("hresp", 32'h0, 32'(hresp));
  endtask
  // One sequencer timeslot pulse, then time to settle
  task automatic strobe(input logic s, input logic [2:0] t);
    seq_strobe <= 1'b1;
    seq_sleep  <= s;
    seq_slot   <= t;
    @(posedge hclk);
    seq_strobe <= 1'b0;
    repeat (3) @(posedge hclk);
  endtask
  // Undervoltage pulse on one converter with a given action code
  task automatic uv(input int b, input logic [15:0] ix, input logic [1:0] act);
    logic irq, rq;
    irq = 1'b0;
    rq  = 1'b0;
    bus(1'b1, ix, {16'h0, act, 14'h0});
    uv_pin[b] <= 1'b1;
    repeat (10) begin
      @(posedge hclk);
      irq |= uv_irq[b];
      rq  |= dev_reset_req;
    end
    uv_pin[b] <= 1'b0;
    repeat (8) @(posedge hclk);
    chk("uv irq", 32'h1, 32'(irq));
    chk("reset req", 32'(act == 2'h2), 32'(rq));
  endtask
  task automatic end_sim;
    $display("mismatches %0d cmp_count %0d", mismatches, cmp_count);
    if (mismatches == 0 && cmp_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // Watchdog cuts a hang short
  initial begin
    #100000;
    mismatches++;
    end_sim();
  end
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    int i;
    logic [31:0] w;
    {hresetn, hsel, hwrite, seq_strobe, seq_sleep, key_open, otp_load} = '0;
    {haddr, hwdata, htrans, hwctl_pin, hwen_pin, uv_pin, seq_slot, otp_vcode} = '0;
    hsize = 3'h2;
    clk_en = 1'b1;
    void'($urandom(84418));
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    // Defaults after reset, then an unmapped word
    for (i = 0; i < 7; i++) begin
      bus(1'b0, csc_pkg::REG_IDX[i], 32'h0);
      chk("reset value", {16'h0, csc_pkg::RSTV[i]}, rd);
    end
    bus(1'b0, 16'h4070, 32'h0);
    chk("unmapped", 32'h0, rd);
    // Random write then read back, undefined bits zero
    key_open <= 1'b1;
    repeat (40) begin
      i = $urandom_range(6);
      w = $urandom;
      bus(1'b1, csc_pkg::REG_IDX[i], w);
      bus(1'b0, csc_pkg::REG_IDX[i], 32'h0);
      chk("readback", {16'h0, w[15:0] & csc_pkg::WMASK[i]}, rd);
    end
    // Range held while key is closed, feedback still written
    bus(1'b1, 16'h4064, 32'h4);
    key_open <= 1'b0;
    bus(1'b1, 16'h4064, 32'h9);
    bus(1'b0, 16'h4064, 32'h0);
    key_open <= 1'b1;
    chk("range locked", 32'h5, rd);
    chk("boost range", 32'h1, 32'(boost_range));
    chk("boost fb", 32'h1, 32'(boost_fb));
    // Hardware control input two forces boost and ext one off
    bus(1'b1, 16'h40F0, 32'h3);
    bus(1'b1, 16'h4064, 32'h1104);
    bus(1'b1, 16'h4066, 32'h1900);
    chk("boost sw on", 32'h1, 32'(boost_en));
    chk("ext sw on", 32'h1, 32'(ext_en[0]));
    hwctl_pin <= 2'h2;
    repeat (8) @(posedge hclk);
    chk("boost forced", 32'h0, 32'(boost_en));
    chk("ext forced", 32'h0, 32'(ext_en[0]));
    hwctl_pin <= 2'h0;
    // Buck enabled only in its own startup slot
    bus(1'b1, 16'h4061, 32'h0080);
    bus(1'b1, 16'h4062, 32'h627F);
    strobe(1'b0, 3'h2);
    chk("buck early", 32'h0, 32'(buck_en));
    strobe(1'b0, 3'h3);
    chk("buck on", 32'h1, 32'(buck_en));
    chk("on mode", 32'h2, 32'(buck_mode));
    chk("vcode clamp", 32'h66, 32'(buck_vcode));
    chk("ovp", 32'h1, 32'(buck_ovp));
    // Sleep transition in timeslot five
    bus(1'b1, 16'h4063, 32'h0010);
    strobe(1'b1, 3'h5);
    chk("sleep mode", 32'h0, 32'(buck_mode));
    chk("sleep vcode", 32'h10, 32'(buck_vcode));
    chk("sleep kept on", 32'h1, 32'(buck_en));
    strobe(1'b0, 3'h0);
    // Preload replaces upper five code bits and clears the low two
    otp_vcode <= 5'h15;
    otp_load  <= 1'b1;
    @(posedge hclk);
    otp_load  <= 1'b0;
    bus(1'b0, 16'h4062, 32'h0);
    chk("preload", 32'h6254, rd);
    // Every undervoltage action on both converters
    for (i = 0; i < 8; i++) uv(i / 4, (i < 4) ? 16'h4061 : 16'h4064, 2'(i % 4));
    chk("buck shut", 32'h0, 32'(buck_en));
    // Buck on hardware enable two; disable code picks its sleep slot
    hwen_pin <= 2'h2;
    bus(1'b1, 16'h4062, 32'hE100);
    bus(1'b1, 16'h4063, 32'h2105);
    repeat (8) @(posedge hclk);
    chk("hw enable", 32'h1, 32'(buck_en));
    strobe(1'b1, 3'h5);
    chk("hw sleep vcode", 32'h5, 32'(buck_vcode));
    chk("hw sleep on", 32'h1, 32'(buck_en));
    // Same code without hardware enable turns the buck off
    bus(1'b1, 16'h4062, 32'h0100);
    strobe(1'b1, 3'h5);
    chk("sleep disable", 32'h0, 32'(buck_en));
    // Frozen clock enable ignores a preload strobe
    clk_en    <= 1'b0;
    otp_vcode <= 5'h1F;
    otp_load  <= 1'b1;
    @(posedge hclk);
    otp_load  <= 1'b0;
    clk_en    <= 1'b1;
    bus(1'b0, 16'h4062, 32'h0);
    chk("frozen preload", 32'h0100, rd);
    end_sim();
  end
endmodule
